// File: core/mufr_pkg.sv
// constants and types of the usb frame responder
// assumes a byte stream from a cdc serial stack outside this block
package mufr_pkg;
  localparam logic [7:0]  MUFR_NET_ADDR   = 8'hff;
  localparam logic [7:0]  MUFR_TYPE_READ  = 8'h03;
  localparam logic [15:0] MUFR_CODE_COORD = 16'h4110;
  localparam logic [15:0] MUFR_CODE_CFG   = 16'h5000;
  localparam logic [15:0] MUFR_MODE_READ  = 16'h0000;
  localparam logic [15:0] MUFR_CRC_COORD  = 16'hc004;
  localparam logic [15:0] MUFR_CRC_CFG    = 16'h0550;
  localparam logic [7:0]  MUFR_LEN_COORD  = 8'h64;
  localparam logic [7:0]  MUFR_LEN_CFG    = 8'h30;
  localparam logic [3:0]  MUFR_REQ_LAST   = 4'h7;
  localparam logic [3:0]  MUFR_REQ_CRC_AT = 4'h6;
  localparam logic [6:0]  MUFR_HDR_BYTES  = 7'h03;
  localparam logic [6:0]  MUFR_LAST_COORD = 7'h68;
  localparam logic [6:0]  MUFR_LAST_CFG   = 7'h34;
  localparam int          MUFR_NUM_REC    = 6;
  localparam logic [6:0]  MUFR_REC_BYTES  = 7'h10;
  localparam logic [6:0]  MUFR_REC_AREA   = 7'h60;
  localparam logic [6:0]  MUFR_PAY_FLAGS  = 7'h60;
  localparam logic [3:0]  MUFR_REC_X      = 4'h1;
  localparam logic [3:0]  MUFR_REC_Y      = 4'h5;
  localparam logic [3:0]  MUFR_REC_Z      = 4'h9;
  localparam logic [3:0]  MUFR_REC_FLAGS  = 4'hd;
  localparam int          MUFR_PEND_BIT   = 2;
  localparam int          MUFR_CFG_BYTES  = 48;
  localparam logic [15:0] MUFR_CRC_POLY   = 16'ha001;
  localparam logic [15:0] MUFR_CRC_INIT   = 16'hffff;
  localparam int unsigned MUFR_PAUSE_MS   = 5000;
  localparam int unsigned MUFR_CLK_KHZ    = 125000;
  localparam int unsigned MUFR_PAUSE_CYC  = MUFR_PAUSE_MS * MUFR_CLK_KHZ;

  typedef struct packed {
    logic [7:0]         addr;
    logic signed [31:0] x;
    logic signed [31:0] y;
    logic signed [31:0] z;
    logic [2:0]         flags;
  } mufr_rec_t;
endpackage

// File: core/mufr_responder.sv
// request decoder and answer framer of the usb modem link
// assumes the usb cdc stack hands over raw binary bytes, one per valid/ready beat,
// and that the streaming engine outside obeys stream_pause
// How it works
// - any valid request pauses periodic streaming for five seconds.
// - requests start with address 0xff; answers echo 0xff first.
// - multibyte fields travel low byte first in both directions.
// - port speed, word length and parity settings are ignored; only bytes count.
// - device appears as cdc serial device carrying raw binary frames.
// - coordinate request carrying checksum c004 counts as correctly protected.
// - coordinate answer is ff,03,64,100 payload bytes,checksum at byte 103.
// - first 96 payload bytes hold six 16-byte latest beacon records.
// - payload byte 96 bit 2 flags pending user data; rest reserved.
// - record holds beacon address then signed x,y,z at offsets 1,5,9.
// - record byte 13 bits 0..2 carry the three beacon flags.
// - config answer is ff,03,30,48 config bytes,checksum at 0x33.
`timescale 1ns/10ps
module mufr_responder
  import mufr_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = MUFR_PAUSE_CYC,
  parameter logic [15:0] CRC_POLY     = MUFR_CRC_POLY,
  parameter logic [15:0] CRC_INIT     = MUFR_CRC_INIT
) (
  input  wire logic                        clk_sys,           // 125 mhz clock
  input  wire logic                        rst_n,             // async reset, low
  input  wire logic                        rx_valid,          // request byte present
  input  wire logic [7:0]                  rx_data,           // request byte
  output logic                             rx_ready,          // request byte taken
  output logic                             tx_valid,          // answer byte present
  output logic [7:0]                       tx_data,           // answer byte
  input  wire logic                        tx_ready,          // answer byte taken
  input  wire mufr_rec_t                   beacon_rec [MUFR_NUM_REC], // latest records
  input  wire logic                        user_data_pending, // user data waiting
  input  wire logic [MUFR_CFG_BYTES*8-1:0] cfg_block,         // config, byte 0 low
  output logic                             stream_pause,      // hold streaming off
  output logic                             err_reply_req,     // pulse: send error reply
  output logic [15:0]                      err_code,          // code of refused request
  output logic [7:0]                       err_type           // type of refused request
);

  typedef enum {MUFR_S_RX, MUFR_S_SEND} mufr_state_t;

  mufr_state_t                 state, next_state;
  logic [3:0]                  rx_cnt, next_rx_cnt;
  logic [63:0]                 req, next_req;
  logic [15:0]                 rx_crc, next_rx_crc;
  logic                        is_cfg, next_is_cfg;
  logic [6:0]                  tx_idx, next_tx_idx;
  logic                        next_tx_valid;
  logic [7:0]                  next_tx_data;
  logic [15:0]                 tx_crc, next_tx_crc;
  mufr_rec_t                   snap_rec [MUFR_NUM_REC];
  mufr_rec_t                   next_snap_rec [MUFR_NUM_REC];
  logic                        snap_pend, next_snap_pend;
  logic [MUFR_CFG_BYTES*8-1:0] snap_cfg, next_snap_cfg;
  logic                        next_err_reply_req;
  logic [15:0]                 next_err_code;
  logic [7:0]                  next_err_type;
  logic [31:0]                 pause_cnt, next_pause_cnt;

  logic        rx_take, frame_end, crc_ok, fixed_ok, req_good, known_coord, known_cfg;
  logic [15:0] rx_crc_got;
  logic [6:0]  last_idx;

  // reflected crc-16, one byte lsb first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] rec_byte(mufr_rec_t r, logic [3:0] off);
    if (off == 4'h0) return r.addr;
    if (off < MUFR_REC_Y) return r.x[8*(off-MUFR_REC_X) +: 8];
    if (off < MUFR_REC_Z) return r.y[8*(off-MUFR_REC_Y) +: 8];
    if (off < MUFR_REC_FLAGS) return r.z[8*(off-MUFR_REC_Z) +: 8];
    if (off == MUFR_REC_FLAGS) return {5'h00, r.flags};
    return 8'h00;
  endfunction

  function automatic logic [7:0] ans_byte(logic cfg, logic [6:0] idx);
    logic [6:0] p;
    p = idx - MUFR_HDR_BYTES;
    if (idx == 7'h00) return MUFR_NET_ADDR;
    if (idx == 7'h01) return MUFR_TYPE_READ;
    if (idx == 7'h02) return cfg ? MUFR_LEN_CFG : MUFR_LEN_COORD;
    if (cfg) return snap_cfg[8*p +: 8];
    if (p < MUFR_REC_AREA) return rec_byte(snap_rec[p[6:4]], p[3:0]);
    if (p == MUFR_PAY_FLAGS) return {7'h00, snap_pend} << MUFR_PEND_BIT;
    return 8'h00;
  endfunction

  // byte stream only: no line settings exist here
  assign rx_ready    = (state == MUFR_S_RX);
  assign rx_take     = rx_valid && rx_ready;
  assign frame_end   = rx_take && (rx_cnt == MUFR_REQ_LAST);
  assign rx_crc_got  = {rx_data, req[55:48]};
  assign crc_ok      = (rx_crc_got == rx_crc);
  assign known_coord = (req[15:8] == MUFR_TYPE_READ) && (req[31:16] == MUFR_CODE_COORD)
                       && (req[47:32] == MUFR_MODE_READ);
  assign known_cfg   = (req[15:8] == MUFR_TYPE_READ) && (req[31:16] == MUFR_CODE_CFG)
                       && (req[47:32] == MUFR_MODE_READ);
  assign fixed_ok    = (known_coord && rx_crc_got == MUFR_CRC_COORD)
                       || (known_cfg && rx_crc_got == MUFR_CRC_CFG);
  assign req_good    = frame_end && (crc_ok || fixed_ok);
  assign last_idx    = is_cfg ? MUFR_LAST_CFG : MUFR_LAST_COORD;
  assign stream_pause = (pause_cnt != 32'h0);

  always_comb begin
    next_state         = state;
    next_rx_cnt        = rx_cnt;
    next_req           = req;
    next_rx_crc        = rx_crc;
    next_is_cfg        = is_cfg;
    next_tx_idx        = tx_idx;
    next_tx_valid      = tx_valid;
    next_tx_data       = tx_data;
    next_tx_crc        = tx_crc;
    next_snap_rec      = snap_rec;
    next_snap_pend     = snap_pend;
    next_snap_cfg      = snap_cfg;
    next_err_reply_req = 1'b0;
    next_err_code      = err_code;
    next_err_type      = err_type;
    unique case (state)
      MUFR_S_RX: begin
        if (rx_take) begin
          if (rx_cnt == 4'h0 && rx_data != MUFR_NET_ADDR) begin
            next_rx_cnt = 4'h0;
          end else if (frame_end) begin
            next_rx_cnt = 4'h0;
            next_rx_crc = CRC_INIT;
            if (req_good && (known_coord || known_cfg)) begin
              next_state     = MUFR_S_SEND;
              next_is_cfg    = known_cfg;
              next_snap_rec  = beacon_rec;
              next_snap_pend = user_data_pending;
              next_snap_cfg  = cfg_block;
              next_tx_idx    = 7'h00;
              next_tx_valid  = 1'b1;
              next_tx_data   = MUFR_NET_ADDR;
              next_tx_crc    = crc_step(CRC_INIT, MUFR_NET_ADDR);
            end else if (req_good) begin
              next_err_reply_req = 1'b1;
              next_err_code      = req[31:16];
              next_err_type      = req[15:8];
            end
          end else begin
            next_req[8*rx_cnt +: 8] = rx_data;
            if (rx_cnt < MUFR_REQ_CRC_AT) begin
              next_rx_crc = crc_step(rx_crc, rx_data);
            end
            next_rx_cnt = rx_cnt + 4'h1;
          end
        end
      end
      MUFR_S_SEND: begin
        if (tx_ready) begin
          if (tx_idx == last_idx) begin
            next_tx_valid = 1'b0;
            next_state    = MUFR_S_RX;
          end else begin
            next_tx_idx = tx_idx + 7'h01;
            if (next_tx_idx == last_idx - 7'h01) begin
              next_tx_data = tx_crc[7:0];
            end else if (next_tx_idx == last_idx) begin
              next_tx_data = tx_crc[15:8];
            end else begin
              next_tx_data = ans_byte(is_cfg, next_tx_idx);
              next_tx_crc  = crc_step(tx_crc, next_tx_data);
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= MUFR_S_RX;
      rx_cnt        <= 4'h0;
      req           <= 64'h0;
      rx_crc        <= CRC_INIT;
      is_cfg        <= 1'b0;
      tx_idx        <= 7'h00;
      tx_valid      <= 1'b0;
      tx_data       <= 8'h00;
      tx_crc        <= CRC_INIT;
      snap_rec      <= '{default: '0};
      snap_pend     <= 1'b0;
      snap_cfg      <= '0;
      err_reply_req <= 1'b0;
      err_code      <= 16'h0000;
      err_type      <= 8'h00;
    end else begin
      state         <= next_state;
      rx_cnt        <= next_rx_cnt;
      req           <= next_req;
      rx_crc        <= next_rx_crc;
      is_cfg        <= next_is_cfg;
      tx_idx        <= next_tx_idx;
      tx_valid      <= next_tx_valid;
      tx_data       <= next_tx_data;
      tx_crc        <= next_tx_crc;
      snap_rec      <= next_snap_rec;
      snap_pend     <= next_snap_pend;
      snap_cfg      <= next_snap_cfg;
      err_reply_req <= next_err_reply_req;
      err_code      <= next_err_code;
      err_type      <= next_err_type;
    end
  end

  // pause timer, restarted by every good request
  always_comb begin
    if (req_good) begin
      next_pause_cnt = 32'(PAUSE_CYCLES);
    end else if (pause_cnt != 32'h0) begin
      next_pause_cnt = pause_cnt - 32'h1;
    end else begin
      next_pause_cnt = 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pause_cnt <= 32'h0;
    end else begin
      pause_cnt <= next_pause_cnt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_pause_load: assert property (req_good |=> pause_cnt == 32'(PAUSE_CYCLES))
    else $error("pause timer not reloaded by request");
  chk_pause_hold: assert property (req_good |=> stream_pause [*8])
    else $error("streaming resumed too early");
  chk_addr_echo: assert property (tx_valid && tx_idx == 7'h00 |->
      tx_data == MUFR_NET_ADDR)
    else $error("answer does not start with network address");
  chk_len_byte: assert property (tx_valid && tx_idx == 7'h02 |->
      tx_data == (is_cfg ? MUFR_LEN_CFG : MUFR_LEN_COORD))
    else $error("wrong answer length byte");
  chk_crc_order: assert property (tx_valid && tx_ready
      && tx_idx == last_idx - 7'h01 |->
      tx_data == tx_crc[7:0] ##1 tx_data == $past(tx_crc[15:8]))
    else $error("checksum bytes wrong or out of order");
  chk_crc_cover: assert property (tx_valid && tx_idx == 7'h00 |-> tx_crc ==
      crc_step(CRC_INIT, MUFR_NET_ADDR))
    else $error("checksum does not start from first byte");
  chk_flag_byte: assert property (tx_valid && !is_cfg && tx_idx == 7'h63 |->
      tx_data == ({7'h00, snap_pend} << MUFR_PEND_BIT))
    else $error("payload flag byte wrong");
  chk_rec_rsvd: assert property (tx_valid && !is_cfg && tx_idx > 7'h02
      && tx_idx < 7'h63 && (tx_idx - 7'h03) % 7'h10 > 7'h0d |-> tx_data == 8'h00)
    else $error("record reserved bytes not zero");
  chk_bad_drop: assert property (frame_end && !(crc_ok || fixed_ok) |=>
      state == MUFR_S_RX && !err_reply_req && !tx_valid)
    else $error("bad checksum frame not dropped");
  chk_cfg_last: assert property (tx_valid && is_cfg |-> tx_idx <= MUFR_LAST_CFG)
    else $error("config answer too long");

  cov_coord_done: cover property (tx_valid && tx_ready && !is_cfg && tx_idx == MUFR_LAST_COORD);
  cov_cfg_done: cover property (tx_valid && tx_ready && is_cfg && tx_idx == MUFR_LAST_CFG);
  cov_bad_crc: cover property (frame_end && !(crc_ok || fixed_ok));
  cov_err_reply: cover property (err_reply_req);

endmodule

// File: tb/mufr_host_model.sv
// host end of the usb serial link: sends request bytes, collects answer bytes
// assumes the responder's valid/ready byte handshake on clk_sys
`timescale 1ns/10ps
module mufr_host_model (
  input  wire logic       clk_sys,  // system clock
  output logic            rx_valid, // request byte present
  output logic [7:0]      rx_data,  // request byte
  input  wire logic       rx_ready, // request byte taken
  input  wire logic       tx_valid, // answer byte present
  input  wire logic [7:0] tx_data,  // answer byte
  output logic            tx_ready, // answer byte taken
  input  wire logic       slow,     // take answer bytes every other cycle
  output logic            stuck     // a request byte was never taken
);
  logic [7:0] ans [$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    stuck    = 1'b0;
  end

  // call at a rising edge; returns at the edge that takes the last byte
  task automatic send(input logic [7:0] req [$]);
    int n;
    foreach (req[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= req[i];
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rx_ready !== 1'b1 && n < 300);
      if (n >= 300)
        stuck <= 1'b1;
    end
    rx_valid <= 1'b0;
    // released line must not keep showing the last byte
    rx_data  <= ~req[req.size()-1];
  endtask

  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready)
      ans.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

// File: tb/tb.sv
// self-checking bench of the usb frame responder
// assumes mufr_pkg and a host model driving the request and answer streams
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h expected %0h", $time, (a), (e)); end end
module tb;
  import mufr_pkg::*;
  localparam int unsigned PAUSE = 50;
  logic                        clk_sys = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        rx_valid, rx_ready, tx_valid, tx_ready;
  logic                        stream_pause, err_reply_req, slow, stuck, pend;
  logic [7:0]                  rx_data, tx_data, err_type;
  logic [15:0]                 err_code;
  logic [MUFR_CFG_BYTES*8-1:0] cfg;
  mufr_rec_t                   recs [MUFR_NUM_REC];
  logic [7:0]                  req [$];
  logic [7:0]                  exp_q [$];
  int                          num_errors = 0;
  int                          checks = 0;
  int                          n_pulse = 0;

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (err_reply_req === 1'b1) n_pulse++;

  mufr_responder #(.PAUSE_CYCLES(PAUSE)) u_mufr_responder (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .beacon_rec(recs), .user_data_pending(pend), .cfg_block(cfg),
    .stream_pause(stream_pause), .err_reply_req(err_reply_req),
    .err_code(err_code), .err_type(err_type));

  mufr_host_model u_mufr_host_model (
    .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow),
    .stuck(stuck));

  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // reflected crc over a byte queue, appended low byte first
  function automatic void seal(ref logic [7:0] q [$]);
    logic [15:0] c;
    c = MUFR_CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ MUFR_CRC_POLY : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  task automatic build_coord();
    logic [95:0] xyz;
    exp_q = '{8'hff, 8'h03, 8'h64};
    foreach (recs[r]) begin
      xyz = {recs[r].z, recs[r].y, recs[r].x};
      exp_q.push_back(recs[r].addr);
      for (int b = 0; b < 12; b++) exp_q.push_back(xyz[8*b +: 8]);
      exp_q.push_back({5'h00, recs[r].flags});
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
    end
    exp_q.push_back({5'h00, pend, 2'h0});
    for (int i = 0; i < 3; i++) exp_q.push_back(8'h00);
    seal(exp_q);
  endtask

  // send req, then compare the whole answer against exp_q
  task automatic ask(input int n);
    int k;
    u_mufr_host_model.send(req);
    repeat (2) @(posedge clk_sys);
    `CHK(rx_ready, 1'b0)
    `CHK(stream_pause, 1'b1)
    k = 0;
    while (u_mufr_host_model.ans.size() < n && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 1000) begin
      num_errors++;
      results();
    end
    foreach (exp_q[i]) `CHK(u_mufr_host_model.ans[i], exp_q[i])
    repeat (3) @(posedge clk_sys);
    `CHK(u_mufr_host_model.ans.size(), n)
    `CHK(tx_valid, 1'b0)
    `CHK(rx_ready, 1'b1)
    u_mufr_host_model.ans.delete();
  endtask

  // well-protected request that is not a supported read
  task automatic run_err(input logic [7:0] t, input logic [15:0] code, input logic [15:0] mode);
    int k;
    int p0;
    p0 = n_pulse;
    req = '{8'hff, t, code[7:0], code[15:8], mode[7:0], mode[15:8]};
    seal(req);
    u_mufr_host_model.send(req);
    repeat (3) @(posedge clk_sys);
    `CHK(stream_pause, 1'b1)
    k = 0;
    while (stream_pause === 1'b1 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK((k > PAUSE - 6) && (k <= PAUSE), 1'b1)
    `CHK(n_pulse - p0, 1)
    `CHK(err_code, code)
    `CHK(err_type, t)
    `CHK(u_mufr_host_model.ans.size(), 0)
  endtask

  initial begin
    pend = 1'b1;
    slow = 1'b0;
    for (int r = 0; r < MUFR_NUM_REC; r++) begin
      recs[r].addr  = 8'ha0 + 8'(r);
      recs[r].x     = 32'hfedc_ba98 - 32'(r);
      recs[r].y     = 32'h1234_5600 + 32'(r);
      recs[r].z     = 32'h8000_0001 + 32'(r);
      recs[r].flags = 3'(r + 2);
    end
    for (int i = 0; i < MUFR_CFG_BYTES; i++) cfg[8*i +: 8] = 8'h40 + 8'(i);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CHK(rx_ready, 1'b1)
    `CHK(tx_valid, 1'b0)
    `CHK(stream_pause, 1'b0)
    req = '{8'hff, 8'h03, 8'h10, 8'h41, 8'h00, 8'h00, 8'h05, 8'hc0};
    u_mufr_host_model.send(req);
    repeat (20) @(posedge clk_sys);
    `CHK(u_mufr_host_model.ans.size(), 0)
    `CHK(stream_pause, 1'b0)
    `CHK(n_pulse, 0)
    slow <= 1'b1;
    req = '{8'hff, 8'h03, 8'h10, 8'h41, 8'h00, 8'h00, 8'h04, 8'hc0};
    build_coord();
    ask(105);
    slow <= 1'b0;
    req = '{8'hff, 8'h03, 8'h00, 8'h50, 8'h00, 8'h00, 8'h50, 8'h05};
    exp_q = '{8'hff, 8'h03, 8'h30};
    for (int i = 0; i < MUFR_CFG_BYTES; i++) exp_q.push_back(cfg[8*i +: 8]);
    seal(exp_q);
    ask(53);
    pend <= 1'b0;
    @(posedge clk_sys);
    req = '{8'h12, 8'hff, 8'h03, 8'h10, 8'h41, 8'h00, 8'h00, 8'h04, 8'hc0};
    build_coord();
    ask(105);
    run_err(8'h03, 16'h1234, 16'h0000);
    run_err(8'h07, 16'h5000, 16'h0000);
    run_err(8'h03, 16'h4110, 16'h0001);
    `CHK(stuck, 1'b0)
    results();
  end
endmodule
